// ===== hw/cbl_pkg.sv
// Constants and types shared by the clock buffer output and lock control.
// Assumes three-level pins arrive as 2-bit level codes from input comparators.
package cbl_pkg;

  // Three-level pin codes; code 2'h3 is never produced by the comparators
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  localparam int NUM_BANKS = 5;
  localparam int NUM_OUTS  = 18;
  localparam int FB_BANK   = 4;
  localparam int B3_BASE   = 8;

  localparam int CLK_PERIOD_NS = 50;
  localparam int PD_LIMIT_NS   = 100;
  localparam int PD_LIMIT_CYC  =
    (PD_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ERR_RUN      = 4;
  localparam int OK_RUN       = 32;
  localparam int WD_REF_EDGES = 8;
  localparam int TRST_EDGES   = 5;

  localparam logic [5:0] CNT_RESET = 6'h00;

  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b01,
    LK_LOCKED   = 2'b10
  } cbl_lock_t;

endpackage : cbl_pkg

// ===== hw/cbl_ctrl.sv
// Output disable, bank-three inversion, lock detect and factory test control
// of a multi-bank PLL clock buffer. Assumes every input is synchronous to
// ref_clk and bank clocks are already divided and skewed levels.
`timescale 1ns/1ps
`default_nettype none

module cbl_ctrl #(
  parameter int WD_EDGES = cbl_pkg::WD_REF_EDGES
) (
  input  wire  logic        ref_clk,
  input  wire  logic        rst,
  input  wire  logic [1:0]  output_mode_level,
  input  wire  logic [1:0]  bank_three_invert_select,
  input  wire  logic [3:0]  bank_disable_inputs,
  input  wire  logic        feedback_bank_disable,
  input  wire  logic        ref_level,
  input  wire  logic        feedback_clock_input,
  input  wire  logic        pll_clk_level,
  input  wire  logic [4:0]  bank_clk,
  output logic              core_clk_level,
  output logic [17:0]       clk_out,
  output logic [17:0]       clk_out_oe,
  output logic              lock,
  output logic              fsm_load,
  output logic              fsm_hold,
  output logic              test_mode
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] three_level(input logic [1:0] code);
    if (code == cbl_pkg::LVL_LOW || code == cbl_pkg::LVL_HIGH)
      return code;
    return cbl_pkg::LVL_MID; // Open pin floats to mid
  endfunction : three_level

  function automatic int bank_of(input int idx);
    return idx / 4;
  endfunction : bank_of

  typedef struct packed {
    logic [4:0]         stopped;
    logic [17:0]        q;
    logic               ref_prev;
    logic               fb_prev;
    logic [5:0]         since_ref;
    logic [2:0]         err_cnt;
    logic [5:0]         ok_cnt;
    logic [5:0]         wd_cnt;
    cbl_pkg::cbl_lock_t lk;
    logic [2:0]         trst_cnt;
    logic               load;
    logic               hold;
  } cbl_state_t;

  cbl_state_t s;
  cbl_state_t next_s;

  logic [1:0]  mode;
  logic [1:0]  inv_sel;
  logic [4:0]  dis;
  logic [17:0] inv_mask;
  logic        ref_rise;
  logic        fb_rise;
  logic        phase_err;
  logic        trst;

  ////////////////////////////////////////////////////////////////////////////
  assign mode      = three_level(output_mode_level);
  assign inv_sel   = three_level(bank_three_invert_select);
  assign dis       = {feedback_bank_disable, bank_disable_inputs};
  assign test_mode = (mode == cbl_pkg::LVL_MID);
  assign trst      = test_mode && bank_disable_inputs[3];
  assign ref_rise  = ref_level && !s.ref_prev;
  assign fb_rise   = feedback_clock_input && !s.fb_prev;
  // Feedback edge too late after reference edge counts as error
  assign phase_err = fb_rise &&
    (s.since_ref > 6'(cbl_pkg::PD_LIMIT_CYC));

  // PLL bypass; dividers downstream keep running on this level
  assign core_clk_level = test_mode ? ref_level : pll_clk_level;

  always_comb
  begin
    inv_mask = 18'h00000;
    // Mask applies to output level only, after divide and skew
    if (inv_sel == cbl_pkg::LVL_LOW)
    begin
      inv_mask[cbl_pkg::B3_BASE + 1] = 1'b1;
      inv_mask[cbl_pkg::B3_BASE + 3] = 1'b1;
    end
    else if (inv_sel == cbl_pkg::LVL_HIGH)
    begin
      inv_mask[cbl_pkg::B3_BASE +: 4] = 4'hf;
    end
  end

  // Enables are combinational so high-Z is not delayed by a clock
  always_comb
  begin
    for (int i = 0; i < cbl_pkg::NUM_OUTS; i++)
    begin
      if (trst)
        clk_out_oe[i] = 1'b0;
      else if (test_mode)
        clk_out_oe[i] = 1'b1;
      else
        clk_out_oe[i] = !(dis[bank_of(i)] &&
          mode == cbl_pkg::LVL_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s          = s;
    next_s.ref_prev = ref_level;
    next_s.fb_prev  = feedback_clock_input;
    next_s.load     = 1'b0;

    // Stop and release only while the bank clock is low, so every output
    // already sits at its stopped level and no runt pulse escapes.
    for (int b = 0; b < cbl_pkg::NUM_BANKS; b++)
    begin
      if (!test_mode && dis[b] && mode == cbl_pkg::LVL_LOW)
      begin
        if (bank_clk[b] == 1'b0)
          next_s.stopped[b] = 1'b1;
      end
      else if (!bank_clk[b])
        next_s.stopped[b] = 1'b0;
    end

    for (int i = 0; i < cbl_pkg::NUM_OUTS; i++)
    begin
      if (next_s.stopped[bank_of(i)])
        next_s.q[i] = inv_mask[i];
      else
        next_s.q[i] = bank_clk[bank_of(i)] ^ inv_mask[i];
    end

    if (ref_rise)
      next_s.since_ref = cbl_pkg::CNT_RESET;
    else if (s.since_ref != 6'h3f)
      next_s.since_ref = s.since_ref + 6'h01;

    // Watchdog counts reference edges, i.e. a divided reference clock
    if (fb_rise)
      next_s.wd_cnt = cbl_pkg::CNT_RESET;
    else if (ref_rise && s.wd_cnt != 6'h3f)
      next_s.wd_cnt = s.wd_cnt + 6'h01;

    if (fb_rise)
    begin
      if (phase_err)
      begin
        next_s.ok_cnt = cbl_pkg::CNT_RESET;
        if (s.err_cnt != 3'h7)
          next_s.err_cnt = s.err_cnt + 3'h1;
      end
      else
      begin
        next_s.err_cnt = 3'h0;
        if (s.ok_cnt != 6'h3f)
          next_s.ok_cnt = s.ok_cnt + 6'h01;
      end
    end

    case (s.lk)
      cbl_pkg::LK_UNLOCKED:
      begin
        if (next_s.ok_cnt >= 6'(cbl_pkg::OK_RUN))
        begin
          next_s.lk      = cbl_pkg::LK_LOCKED;
          next_s.err_cnt = 3'h0;
        end
      end
      cbl_pkg::LK_LOCKED:
      begin
        if (next_s.err_cnt >= 3'(cbl_pkg::ERR_RUN) ||
            s.wd_cnt >= 6'(WD_EDGES))
        begin
          next_s.lk      = cbl_pkg::LK_UNLOCKED;
          next_s.err_cnt = 3'h0;
          next_s.ok_cnt  = cbl_pkg::CNT_RESET;
          next_s.wd_cnt  = cbl_pkg::CNT_RESET;
        end
      end
      default:
        next_s.lk = cbl_pkg::LK_UNLOCKED;
    endcase

    // Test reset: count reference edges, then load and hold
    if (!trst)
    begin
      next_s.trst_cnt = 3'h0;
      next_s.hold     = 1'b0;
    end
    else if (ref_rise && s.trst_cnt < 3'(cbl_pkg::TRST_EDGES))
    begin
      next_s.trst_cnt = s.trst_cnt + 3'h1;
      if (s.trst_cnt == 3'(cbl_pkg::TRST_EDGES - 1))
      begin
        next_s.load = 1'b1;
        next_s.hold = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s          <= '0;
      s.lk       <= cbl_pkg::LK_UNLOCKED;
      s.ref_prev <= 1'b1;
      s.fb_prev  <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign clk_out  = s.q;
  assign lock     = (s.lk == cbl_pkg::LK_LOCKED);
  assign fsm_load = s.load;
  assign fsm_hold = s.hold;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_enabled_follows;
    !test_mode && !dis[0] && !s.stopped[0] && !$past(s.stopped[0])
      |=> clk_out[1] == $past(bank_clk[0]);
  endproperty
  a_enabled_follows: assert property (p_enabled_follows)
    else $error("Enabled bank does not follow its clock");

  property p_hiz;
    !test_mode && dis[2] && mode == cbl_pkg::LVL_HIGH |-> !clk_out_oe[9];
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("High-Z disable did not release outputs");

  property p_fb_hiz;
    !test_mode && dis[4] && mode == cbl_pkg::LVL_HIGH
      |-> clk_out_oe[17:16] == 2'h0;
  endproperty
  a_fb_hiz: assert property (p_fb_hiz)
    else $error("Feedback bank not released to high-Z");

  property p_stop_in_time;
    (!test_mode && dis[1] && mode == cbl_pkg::LVL_LOW && !bank_clk[1]) [*2]
      |=> s.stopped[1];
  endproperty
  a_stop_in_time: assert property (p_stop_in_time)
    else $error("Bank not stopped after clock went low");

  property p_stop_levels;
    s.stopped[2] |-> clk_out[8] == ($past(inv_sel) == cbl_pkg::LVL_HIGH) &&
      clk_out[9] == ($past(inv_sel) != cbl_pkg::LVL_MID);
  endproperty
  a_stop_levels: assert property (p_stop_levels)
    else $error("Stopped outputs at wrong level");

  property p_inv_high;
    inv_sel == cbl_pkg::LVL_HIGH && !s.stopped[2] && !$past(s.stopped[2])
      |=> clk_out[11:8] == {4{~$past(bank_clk[2])}};
  endproperty
  a_inv_high: assert property (p_inv_high)
    else $error("Bank three output not inverted");

  property p_inv_low;
    inv_sel == cbl_pkg::LVL_LOW && !s.stopped[2]
      |=> clk_out[11:8] == {~$past(bank_clk[2]), $past(bank_clk[2]),
                            ~$past(bank_clk[2]), $past(bank_clk[2])};
  endproperty
  a_inv_low: assert property (p_inv_low)
    else $error("Bank three pairs not complementary");

  property p_err_unlock;
    lock && phase_err ##0 (s.err_cnt == 3'h3) |=> !lock;
  endproperty
  a_err_unlock: assert property (p_err_unlock)
    else $error("Lock kept after four error cycles");

  property p_lock_needs_run;
    $rose(lock) |-> $past(s.ok_cnt) == 6'h1f && $past(fb_rise);
  endproperty
  a_lock_needs_run: assert property (p_lock_needs_run)
    else $error("Lock raised without 32 clean cycles");

  property p_watchdog;
    lock && s.wd_cnt >= 6'(WD_EDGES) |=> !lock;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("Watchdog did not drop lock");

  property p_trst_hiz;
    trst |-> clk_out_oe == 18'h00000;
  endproperty
  a_trst_hiz: assert property (p_trst_hiz)
    else $error("Outputs driven during test reset");

  property p_bypass;
    test_mode |-> core_clk_level == ref_level;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("PLL not bypassed in test mode");

  property p_load;
    fsm_load |-> fsm_hold && s.trst_cnt == 3'(cbl_pkg::TRST_EDGES);
  endproperty
  a_load: assert property (p_load)
    else $error("State load not on fifth reference edge");

  c_lock: cover property ($rose(lock));
  c_unlock: cover property ($fell(lock));
  c_stop: cover property ($rose(s.stopped[0]));
  c_trst: cover property ($rose(fsm_load));
  c_hiz: cover property (!clk_out_oe[0]);

endmodule : cbl_ctrl

`default_nettype wire

// ===== testbench/cbl_src.sv
// Board-side model: reference, PLL, bank and feedback clock levels.
// Assumes the bench sets fb_dly and fb_run at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module cbl_src (
  input  wire logic       ref_clk,
  input  wire logic [2:0] fb_dly,
  input  wire logic       fb_run,
  output logic            ref_level,
  output logic            feedback_clock_input,
  output logic            pll_clk_level,
  output logic [4:0]      bank_clk
);
  logic [3:0] ph = 4'h0;
  logic [2:0] fb_ph;

  always @(negedge ref_clk)
  begin
    ph <= ph + 4'h1;
  end

  assign fb_ph     = ph[2:0] - fb_dly;
  assign ref_level = ~ph[2];
  // Stopped feedback sits low, which also covers test operation
  assign feedback_clock_input = fb_run & ~fb_ph[2];
  assign pll_clk_level = ph[0];
  assign bank_clk      = {5{ph[3]}};
endmodule : cbl_src
`default_nettype wire

// ===== testbench/cbl_ctrl_bench.sv
// Self-checking bench: disables, bank-three inversion, lock, test reset.
// Assumes cbl_src supplies every clock level; inputs move at falling edge.
`timescale 1ns/1ps
`default_nettype none

module cbl_ctrl_bench;
  localparam int WD = 4;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [1:0]  inv = 2'h0;
  logic [4:0]  dis = 5'h00;
  logic [2:0]  fb_dly = 3'h1;
  logic        fb_run = 1'b0;
  logic        ref_level, fb_clk, pll_lvl, core_lvl;
  logic        lock, load, hold, tmode;
  logic        fb_q = 1'b1;
  logic        ref_q = 1'b1;
  logic [4:0]  bank_clk;
  logic [17:0] clk_out, oe, hx;
  logic [1:0]  isel [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  logic [3:0]  iexp [4] = '{4'h5, 4'h0, 4'hf, 4'hf};
  int          err_total = 0;
  int          num_checks = 0;
  int          fb_cnt = 0;
  int          ref_cnt = 0;
  int          fb_base = 0;
  int          ref_base = 0;

  always #25 ref_clk = ~ref_clk;

  cbl_src src (.ref_clk(ref_clk), .fb_dly(fb_dly), .fb_run(fb_run),
    .ref_level(ref_level), .feedback_clock_input(fb_clk),
    .pll_clk_level(pll_lvl), .bank_clk(bank_clk));

  cbl_ctrl #(.WD_EDGES(WD)) DUT (.ref_clk(ref_clk), .rst(rst),
    .output_mode_level(mode), .bank_three_invert_select(inv),
    .bank_disable_inputs(dis[3:0]), .feedback_bank_disable(dis[4]),
    .ref_level(ref_level), .feedback_clock_input(fb_clk),
    .pll_clk_level(pll_lvl), .bank_clk(bank_clk),
    .core_clk_level(core_lvl), .clk_out(clk_out), .clk_out_oe(oe),
    .lock(lock), .fsm_load(load), .fsm_hold(hold), .test_mode(tmode));

  always @(posedge ref_clk)
  begin
    fb_q <= fb_clk;
    ref_q <= ref_level;
    if (fb_clk && !fb_q) fb_cnt <= fb_cnt + 1;
    if (ref_level && !ref_q) ref_cnt <= ref_cnt + 1;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Feedback changes only just after a reference rise, so no stray edge
  task automatic ref_sync();
    int c;
    c = ref_cnt;
    while (ref_cnt == c) cyc(1);
  endtask : ref_sync

  task automatic wait_lock(input logic lv, input int lim);
    int n;
    n = 0;
    while (lock !== lv && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk(18'(lock), 18'(lv));
  endtask : wait_lock

  task automatic inv_chk(input logic [3:0] e);
    while (bank_clk[2] !== 1'b0) cyc(1);
    while (bank_clk[2] !== 1'b1) cyc(1);
    cyc(2);
    chk(18'(clk_out[11:8]), 18'(e));
    cyc(8);
    chk(18'(clk_out[11:8]), 18'(e ^ 4'hf));
  endtask : inv_chk

  function automatic logic [17:0] bmask(input int b);
    return (b < 4) ? 18'(18'hf << (4 * b)) : 18'h30000;
  endfunction : bmask

  initial
  begin
    cyc(5);
    chk(clk_out, 18'h0);
    chk(18'({lock, load, hold}), 18'h0);
    rst = 1'b0;
    #1;
    chk(oe, 18'h3ffff);
    chk(18'(core_lvl), 18'(pll_lvl));
    // Select only moves between sections, never during one
    mode = 2'h2;
    for (int b = 0; b < 5; b++)
    begin
      dis = 5'(1 << b);
      #1;
      chk(oe, ~bmask(b));
      cyc(1);
      dis = 5'h00;
      #1;
      chk(oe, 18'h3ffff);
      cyc(1);
    end
    mode = 2'h0;
    for (int b = 0; b < 5; b++)
    begin
      dis = 5'(1 << b);
      hx = (b == 2) ? 18'h00a00 : 18'h0;
      cyc(32);
      repeat (16)
      begin
        cyc(1);
        chk(clk_out & bmask(b), hx);
        chk(oe, 18'h3ffff);
      end
      dis = 5'h00;
      cyc(40);
    end
    ref_sync();
    fb_run = 1'b1;
    fb_base = fb_cnt;
    wait_lock(1'b1, 400);
    chk(18'(fb_cnt - fb_base), 18'h20);
    ref_sync();
    fb_dly = 3'h4;
    fb_base = fb_cnt;
    wait_lock(1'b0, 80);
    chk(18'(fb_cnt - fb_base), 18'h4);
    ref_sync();
    fb_dly = 3'h1;
    fb_base = fb_cnt;
    wait_lock(1'b1, 400);
    chk(18'(fb_cnt - fb_base), 18'h20);
    ref_sync();
    fb_run = 1'b0;
    cyc(8);
    chk(18'(lock), 18'h1);
    wait_lock(1'b0, 40);
    for (int m = 0; m < 2; m++)
    begin
      mode = m ? 2'h1 : 2'h0;
      for (int i = 0; i < 4; i++)
      begin
        inv = isel[i];
        inv_chk(iexp[i]);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      mode = 2'(k);
      #1;
      chk(18'(tmode), 18'(k % 2));
    end
    mode = 2'h1;
    dis = 5'h17;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      #1;
      chk(oe, 18'h3ffff);
      chk(18'(core_lvl), 18'(ref_level));
    end
    dis = 5'h08;
    ref_base = ref_cnt;
    #1;
    chk(oe, 18'h0);
    while (load !== 1'b1 && (ref_cnt - ref_base) < 8) cyc(1);
    chk(18'(ref_cnt - ref_base), 18'h5);
    chk(18'({load, hold}), 18'h3);
    cyc(1);
    chk(18'({load, hold}), 18'h1);
    chk(oe, 18'h0);
    dis = 5'h00;
    cyc(1);
    chk(18'({hold, tmode}), 18'h1);
    chk(oe, 18'h3ffff);
    conclude();
  end

  // The sequence needs under 2000 cycles; ten times that means a hang
  initial
  begin
    cyc(20000);
    err_total++;
    conclude();
  end
endmodule : cbl_ctrl_bench
`default_nettype wire
